// [logic/rmb_ebuf.sv]
// Purpose: Bit-wide receive elasticity buffer
// Assumes: One push bit per cycle at most, pop of up to 4 bits
// Notes:   Pushes dropped here when full; caller guards underrun
`timescale 1ns/1ps
`default_nettype none
module rmb_ebuf (
    input  wire logic                    mclk_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    clr_i,
    input  wire logic                    push_i,
    input  wire logic                    bit_i,
    input  wire logic                    pop_i,
    input  wire logic [2:0]              pop_n_i,
    output logic      [rmb_pkg::DW-1:0]  data_o,
    output logic      [rmb_pkg::PTR_W-1:0] count_o,
    output logic                         full_o
);
    logic [rmb_pkg::BUF_BITS-1:0] mem_q;
    logic [rmb_pkg::PTR_W-1:0]    wr_q;
    logic [rmb_pkg::PTR_W-1:0]    rd_q;
    wire  [rmb_pkg::PTR_W-2:0]    wr_idx = wr_q[rmb_pkg::PTR_W-2:0];
    wire                          do_push = push_i && !full_o;

    assign count_o = wr_q - rd_q;
    assign full_o  = (count_o == 6'(rmb_pkg::BUF_BITS));

    // Oldest bit in data_o[0]
    genvar g;
    generate
        for (g = 0; g < rmb_pkg::DW; g++) begin : g_rd
            wire [rmb_pkg::PTR_W-2:0] idx = rd_q[rmb_pkg::PTR_W-2:0] + 5'(g);
            assign data_o[g] = mem_q[idx];
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem_q <= '0;
        end else if (do_push) begin
            mem_q[wr_idx] <= bit_i;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (clr_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 6'h01;
            end
            if (pop_i) begin
                rd_q <= rd_q + {3'h0, pop_n_i};
            end
        end
    end
endmodule
`default_nettype wire

// [logic/rmb_link_if.sv]
// Purpose: Link between the media port device and the MAC
// Assumes: Single clock; ref_clk is the device-made reference
// Notes:   Data lanes 4 bits wide, low 2 used in reduced-pin mode
`timescale 1ns/1ps
`default_nettype none
interface rmb_link_if;
    logic       tx_en;
    logic [3:0] txd;
    logic       crs_dv;
    logic       rx_dv;
    logic       rx_er;
    logic [3:0] rxd;
    logic       ref_clk;
    modport phy (input tx_en, txd, output crs_dv, rx_dv, rx_er, rxd, ref_clk);
    modport mac (output tx_en, txd, input crs_dv, rx_dv, rx_er, rxd, ref_clk);
endinterface
`default_nettype wire

// [logic/rmb_mac.sv]
// Purpose: MAC end of the reduced media port
// Assumes: Timed by mclk_i, the common external reference
// Notes:   Device reference output is not used for timing
`timescale 1ns/1ps
`default_nettype none
module rmb_mac (
    input  wire logic       mclk_i,
    input  wire logic       reset_n_i,
    rmb_link_if.mac         link,
    input  wire logic       rmii_i,
    input  wire logic       spd10_i,
    input  wire logic       tx_valid_i,
    input  wire logic [3:0] tx_data_i,
    output logic            tx_ready_o,
    output logic            rx_valid_o,
    output logic      [3:0] rx_data_o,
    output logic            rx_err_o,
    output logic            crs_o
);
    logic [3:0] pace_q;
    logic       tx_en_q;
    logic [3:0] txd_q;
    logic       rx_valid_q;
    logic [3:0] rx_data_q;
    logic       rx_err_q;
    logic       crs_q;

    // Own pacing from the shared reference, not the device clock out
    wire tick = !spd10_i || (pace_q == rmb_pkg::PACE_LAST);
    wire [3:0] mask = rmii_i ? 4'h3 : 4'hF;

    assign tx_ready_o = tick;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pace_q     <= 4'h0;
            tx_en_q    <= 1'b0;
            txd_q      <= 4'h0;
            rx_valid_q <= 1'b0;
            rx_data_q  <= 4'h0;
            rx_err_q   <= 1'b0;
            crs_q      <= 1'b0;
        end else begin
            pace_q     <= tick ? 4'h0 : pace_q + 4'h1;
            rx_valid_q <= tick && link.rx_dv;
            if (tick) begin
                tx_en_q   <= tx_valid_i;
                txd_q     <= tx_valid_i ? (tx_data_i & mask) : 4'h0;
                rx_data_q <= link.rxd & mask;
                rx_err_q  <= link.rx_er;
                crs_q     <= link.crs_dv;
            end
        end
    end

    assign link.tx_en = tx_en_q;
    assign link.txd   = txd_q;
    assign rx_valid_o = rx_valid_q;
    assign rx_data_o  = rx_data_q;
    assign rx_err_o   = rx_err_q;
    assign crs_o      = crs_q;
endmodule
`default_nettype wire

// [logic/rmb_phy.sv]
// Purpose: Device end of the reduced media port with receive elasticity buffer
// Assumes: mclk_i is the interface reference; line bits arrive synchronous
// Notes:   Bypass control register on a plain strobe port
//
// Summary of operation
// - Reduced-pin data moves two bits per reference clock
// - Separate receive data valid in reduced-pin mode
// - Receive error on symbol, false carrier, buffer faults
// - Corrupt delivered data after any receive error
// - 10 Mb/s: sample transmit every 10 clocks
// - 10 Mb/s: new receive value every 10 clocks
// - Buffer fault forces a frame check error
// - Underrun and overrun readable in bypass register
// - Two-bit start threshold, reduced-pin latency table
// - Single-clock nibble threshold table
// - Reduced-pin master mode drives reference clock out
// - Master reference out runs half rate in reset
// - Reduced-pin slave mode halves reference for core logic
// - MAC takes reference from common external source
// - Single-clock nibble mode uses only reference clock
// - Single-clock 10 Mb/s paces every 10 clocks
// - Receive single-clock enable sets threshold; transmit enable bit is stored but unused
// - Single-clock receive uses the elasticity buffer
// - Software picks threshold suiting both speeds
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rmb_phy (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    rmb_link_if.phy          link,
    input  wire logic [3:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        phy_reset_i,
    input  wire logic        rx_active_i,
    input  wire logic        rx_bit_valid_i,
    input  wire logic        rx_bit_i,
    input  wire logic        rx_sym_err_i,
    input  wire logic        rx_false_carrier_i,
    output logic             tx_valid_o,
    output logic             tx_en_o,
    output logic      [3:0]  tx_data_o,
    output logic             core_en_o
);
    typedef enum logic [1:0] {RX_IDLE, RX_FILL, RX_RUN} rmb_rx_state_t;

    logic [15:0]               ctrl_q;
    logic                      under_q;
    logic                      over_q;
    logic [15:0]               rdata_q;
    logic [3:0]                pace_q;
    logic [1:0]                refc_q;
    logic                      ref_q;
    logic                      half_q;
    rmb_rx_state_t             st_q;
    rmb_rx_state_t             st_d;
    logic                      err_pend_q;
    logic                      corrupt_q;
    logic [3:0]                rxd_q;
    logic                      rx_dv_q;
    logic                      rx_er_q;
    logic                      crs_dv_q;
    logic                      tx_valid_q;
    logic                      tx_en_q;
    logic [3:0]                tx_data_q;
    logic [rmb_pkg::DW-1:0]    buf_data;
    logic [rmb_pkg::PTR_W-1:0] buf_cnt;
    logic                      buf_full;

    wire rmii   = ctrl_q[rmb_pkg::F_RMII];
    wire master = ctrl_q[rmb_pkg::F_MASTER];
    wire spd10  = ctrl_q[rmb_pkg::F_SPD10];
    wire scm_tx = ctrl_q[rmb_pkg::F_SCM_TX];
    wire scm_rx = ctrl_q[rmb_pkg::F_SCM_RX];
    wire [1:0] thr_code = ctrl_q[rmb_pkg::F_THR +: 2];

    // Register decode
    wire sel_bp    = (addr_i == rmb_pkg::ADDR_BYPASS);
    wire wr_bp     = wr_i && sel_bp;
    wire [15:0] bp_val = (ctrl_q & rmb_pkg::CTRL_MASK)
                       | (16'(under_q) << rmb_pkg::F_UNDER)
                       | (16'(over_q) << rmb_pkg::F_OVER);
    wire [15:0] rd_mux = sel_bp ? bp_val : 16'h0000;

    // Pacing: every clock at 100 Mb/s, every tenth at 10 Mb/s
    wire tick    = !spd10 || (pace_q == rmb_pkg::PACE_LAST);
    wire [2:0] lane_rx = rmii ? rmb_pkg::LANE_RMII : rmb_pkg::LANE_NIB;
    wire [2:0] lane_tx = rmii ? rmb_pkg::LANE_RMII : rmb_pkg::LANE_NIB;
    wire [rmb_pkg::PTR_W-1:0] thr =
        rmb_pkg::thr_bits(thr_code, !rmii && scm_rx, spd10);
    wire [rmb_pkg::PTR_W-1:0] lane_w = {3'h0, lane_rx};

    // Receive drain control
    wire enough    = (buf_cnt >= lane_w);
    wire run_tick  = (st_q == RX_RUN) && tick;
    wire pop       = run_tick && enough;
    wire under_ev  = run_tick && !enough && rx_active_i;
    wire over_ev   = rx_bit_valid_i && buf_full;
    wire flush     = (st_d == RX_IDLE) && (st_q != RX_IDLE);
    wire err_ev    = (rx_sym_err_i && st_q != RX_IDLE) || rx_false_carrier_i
                   || under_ev || over_ev;
    wire [3:0] lane_mask = rmii ? 4'h3 : 4'hF;
    wire [3:0] out_data  = (buf_data ^ {4{corrupt_q || err_pend_q}}) & lane_mask;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            RX_IDLE: if (rx_active_i) begin
                st_d = RX_FILL;
            end
            RX_FILL: if (buf_cnt >= thr) begin
                st_d = RX_RUN;
            end else if (!rx_active_i && !rx_bit_valid_i) begin
                st_d = RX_IDLE;
            end
            RX_RUN: if (run_tick && !enough && !rx_active_i) begin
                st_d = RX_IDLE;
            end
        endcase
    end

    rmb_ebuf u_ebuf (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .clr_i     (flush),
        .push_i    (rx_bit_valid_i && st_q != RX_IDLE),
        .bit_i     (rx_bit_i),
        .pop_i     (pop),
        .pop_n_i   (lane_rx),
        .data_o    (buf_data),
        .count_o   (buf_cnt),
        .full_o    (buf_full)
    );

    // Bypass control register
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q  <= rmb_pkg::BYPASS_RST;
            under_q <= 1'b0;
            over_q  <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            if (wr_bp) begin
                ctrl_q <= wdata_i & rmb_pkg::CTRL_MASK;
            end
            under_q <= under_ev || (under_q && !(wr_bp && wdata_i[rmb_pkg::F_UNDER]));
            over_q  <= over_ev || (over_q && !(wr_bp && wdata_i[rmb_pkg::F_OVER]));
            rdata_q <= rd_i ? rd_mux : 16'h0000;
        end
    end

    // Pacing and clock generation
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pace_q <= 4'h0;
            refc_q <= 2'h0;
            ref_q  <= 1'b0;
            half_q <= 1'b0;
        end else begin
            pace_q <= tick ? 4'h0 : pace_q + 4'h1;
            half_q <= !half_q;
            if (refc_q >= (phy_reset_i ? rmb_pkg::REF_HALF_RST : rmb_pkg::REF_HALF_RUN)) begin
                refc_q <= 2'h0;
                ref_q  <= !ref_q;
            end else begin
                refc_q <= refc_q + 2'h1;
            end
        end
    end

    // Receive state and outputs
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q       <= RX_IDLE;
            err_pend_q <= 1'b0;
            corrupt_q  <= 1'b0;
            rxd_q      <= 4'h0;
            rx_dv_q    <= 1'b0;
            rx_er_q    <= 1'b0;
            crs_dv_q   <= 1'b0;
        end else begin
            st_q       <= st_d;
            err_pend_q <= err_ev || (err_pend_q && !tick);
            if (st_q == RX_IDLE) begin
                corrupt_q <= 1'b0;
            end else if (err_ev || (err_pend_q && tick && pop)) begin
                corrupt_q <= 1'b1;
            end
            if (tick) begin
                rxd_q    <= pop ? out_data : 4'h0;
                rx_dv_q  <= pop;
                rx_er_q  <= err_ev || err_pend_q;
                crs_dv_q <= pop || rx_active_i;
            end
        end
    end

    // Transmit sampling
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_valid_q <= 1'b0;
            tx_en_q    <= 1'b0;
            tx_data_q  <= 4'h0;
        end else begin
            tx_valid_q <= tick && link.tx_en;
            if (tick) begin
                tx_en_q   <= link.tx_en;
                tx_data_q <= link.txd & (rmii ? 4'h3 : 4'hF);
            end
        end
    end

    assign link.rxd     = rxd_q;
    assign link.rx_dv   = rx_dv_q;
    assign link.rx_er   = rx_er_q;
    assign link.crs_dv  = crs_dv_q;
    assign link.ref_clk = master && rmii && ref_q;
    assign core_en_o    = (rmii && !master) ? half_q : 1'b1;
    assign rdata_o      = rdata_q;
    assign tx_valid_o   = tx_valid_q;
    assign tx_en_o      = tx_en_q;
    assign tx_data_o    = tx_data_q;
    // Single-clock nibble transmit shares the same pacing path
    wire unused_tx = scm_tx && lane_tx[0];
endmodule
`default_nettype wire

// [logic/rmb_pkg.sv]
// Purpose: Shared constants for the reduced media port and its elastic buffer
// Assumes: One clock, mclk_i, standing in for the interface reference
// Notes:   Threshold table held as a function
`default_nettype none
package rmb_pkg;
    localparam int         DW       = 4;
    localparam int         BUF_BITS = 32;
    localparam int         PTR_W    = 6;
    localparam logic [3:0] ADDR_BYPASS = 4'h0;
    localparam int         F_THR    = 0;
    localparam int         F_SCM_TX = 2;
    localparam int         F_SCM_RX = 3;
    localparam int         F_RMII   = 4;
    localparam int         F_MASTER = 5;
    localparam int         F_SPD10  = 6;
    localparam int         F_UNDER  = 8;
    localparam int         F_OVER   = 9;
    localparam logic [15:0] BYPASS_RST = 16'h0011;
    localparam logic [15:0] CTRL_MASK  = 16'h007F;
    localparam logic [3:0]  PACE_LAST  = 4'h9;
    localparam logic [1:0]  REF_HALF_RUN = 2'h0;
    localparam logic [1:0]  REF_HALF_RST = 2'h1;
    localparam logic [2:0]  LANE_RMII  = 3'h2;
    localparam logic [2:0]  LANE_NIB   = 3'h4;

    // Start threshold in bits
    function automatic logic [PTR_W-1:0] thr_bits(input logic [1:0] code,
                                                  input logic scm, input logic spd10);
        logic [PTR_W-1:0] r;
        r = 6'h08;
        if (scm) begin
            r = (spd10 || code == 2'h3 || code == 2'h0) ? 6'h08 : 6'h04;
        end else if (spd10) begin
            unique case (code)
                2'h1: r = 6'h08;
                2'h2: r = 6'h04;
                2'h3: r = 6'h08;
                2'h0: r = 6'h0C;
            endcase
        end else begin
            unique case (code)
                2'h1: r = 6'h02;
                2'h2: r = 6'h06;
                2'h3: r = 6'h0A;
                2'h0: r = 6'h0E;
            endcase
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// [tb/rmb_assertions.sv]
// Purpose: Link checks for the media port pair
// Assumes: One clock domain, reset_n_i async low
// Notes:   Mode inputs are the bench-driven pins
`timescale 1ns/1ps
`default_nettype none
module rmb_assertions (
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    input wire logic       tx_en,
    input wire logic [3:0] txd,
    input wire logic       crs_dv,
    input wire logic       rx_dv,
    input wire logic       rx_er,
    input wire logic [3:0] rxd,
    input wire logic       ref_clk,
    input wire logic       rmii_i,
    input wire logic       spd10_i,
    input wire logic       phy_reset_i,
    input wire logic       rx_sym_err_i,
    input wire logic       rx_false_carrier_i
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    property p_tx_mask;
        rmii_i && tx_en |-> txd[3:2] == 2'h0;
    endproperty
    a_tx_mask: assert property (p_tx_mask) else $error("tx upper bits set");
    property p_dv_crs;
        rx_dv |-> crs_dv;
    endproperty
    a_dv_crs: assert property (p_dv_crs) else $error("rx valid without crs");
    property p_sym_err;
        rx_sym_err_i && rx_dv && !spd10_i |-> ##[1:4] rx_er;
    endproperty
    a_sym_err: assert property (p_sym_err) else $error("symbol error lost");
    property p_fc_err;
        rx_false_carrier_i && !spd10_i |-> ##[1:4] rx_er;
    endproperty
    a_fc_err: assert property (p_fc_err) else $error("false carrier lost");
    property p_tx_paced;
        spd10_i && $changed({tx_en, txd}) |=> $stable({tx_en, txd})[*8];
    endproperty
    a_tx_paced: assert property (p_tx_paced) else $error("tx pacing");
    property p_rx_paced;
        spd10_i && $changed({crs_dv, rx_dv, rx_er, rxd}) |=>
            $stable({crs_dv, rx_dv, rx_er, rxd})[*8];
    endproperty
    a_rx_paced: assert property (p_rx_paced) else $error("rx pacing");
    property p_ref_run;
        !phy_reset_i && !$past(phy_reset_i) && $rose(ref_clk) |=> $fell(ref_clk);
    endproperty
    a_ref_run: assert property (p_ref_run) else $error("ref clock rate");
    property p_ref_slow;
        phy_reset_i && $past(phy_reset_i, 2) && $rose(ref_clk) |=> ref_clk ##1 !ref_clk;
    endproperty
    a_ref_slow: assert property (p_ref_slow) else $error("ref clock in reset");
    c_dv: cover property (rx_dv ##1 !rx_dv);
    c_err: cover property ($rose(rx_er));
    c_slow: cover property (phy_reset_i && $rose(ref_clk));
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench for the media port pair
// Assumes: Both ends on mclk_i at 125 MHz
// Notes:   Rows cover thresholds and pacing; faults follow
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct { logic [15:0] cfg; int nb; int gap; } rmb_row_t;
    logic        mclk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic        phy_reset_i = 1'b0, rx_active_i = 1'b0, rx_bit_valid_i = 1'b0;
    logic        rx_bit_i = 1'b0, rx_sym_err_i = 1'b0, rx_false_carrier_i = 1'b0;
    logic        rmii_i = 1'b1, spd10_i = 1'b0, tx_valid_i = 1'b0, err_seen;
    logic [3:0]  addr_i = 4'h0, tx_data_i = 4'h0, tx_data_o, rx_data_o;
    logic [15:0] wdata_i = 16'h0000, rdata_o;
    logic        tx_valid_o, core_en_o, tx_ready_o, rx_valid_o, rx_err_o, tx_en_o, crs_o;
    logic [31:0] got;
    int          failures = 0, checks = 0, cyc = 0, ngot = 0, lane = 2;
    logic [3:0]  tx_q [$];
    int          tx_c [$];
    localparam logic [31:0] PAT = 32'hC3A5_96E1;
    rmb_row_t    rows [10] = '{'{16'h0011, 2, 1}, '{16'h0012, 6, 1}, '{16'h0013, 10, 1},
        '{16'h0010, 14, 1}, '{16'h0051, 8, 10}, '{16'h0052, 4, 10}, '{16'h0050, 12, 10},
        '{16'h000D, 4, 1}, '{16'h000F, 8, 1}, '{16'h004E, 8, 10}};

    always #4 mclk_i = ~mclk_i;
    rmb_link_if link ();
    rmb_phy u_rmb_phy (.mclk_i, .reset_n_i, .link, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .phy_reset_i, .rx_active_i, .rx_bit_valid_i, .rx_bit_i, .rx_sym_err_i,
        .rx_false_carrier_i, .tx_valid_o, .tx_en_o, .tx_data_o, .core_en_o);
    rmb_mac u_rmb_mac (.mclk_i, .reset_n_i, .link, .rmii_i, .spd10_i, .tx_valid_i,
        .tx_data_i, .tx_ready_o, .rx_valid_o, .rx_data_o, .rx_err_o, .crs_o);
    rmb_assertions u_rmb_assertions (.mclk_i, .reset_n_i, .tx_en(link.tx_en),
        .txd(link.txd), .crs_dv(link.crs_dv), .rx_dv(link.rx_dv), .rx_er(link.rx_er),
        .rxd(link.rxd), .ref_clk(link.ref_clk), .rmii_i, .spd10_i, .phy_reset_i,
        .rx_sym_err_i, .rx_false_carrier_i);

    always @(posedge mclk_i) begin
        cyc++;
        if (rx_valid_o === 1'b1) begin
            for (int j = 0; j < lane; j++) begin
                if (ngot < 32) got[ngot] = rx_data_o[j];
                ngot++;
            end
        end
        if (rx_err_o === 1'b1) err_seen = 1'b1;
        if (tx_valid_o === 1'b1) begin
            tx_q.push_back(tx_data_o);
            tx_c.push_back(cyc);
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        chk(rdata_o & m, exp);
        @(posedge mclk_i);
    endtask
    task automatic set_cfg(input logic [15:0] c);
        rmii_i <= c[4];
        spd10_i <= c[6];
        lane = c[4] ? 2 : 4;
        wr(4'h0, c);
    endtask
    task automatic rx_pkt(input int n, input int hold);
        got = '0;
        ngot = 0;
        err_seen = 1'b0;
        rx_active_i <= 1'b1;
        @(posedge mclk_i);
        for (int i = 0; i < n; i++) begin
            rx_bit_valid_i <= 1'b1;
            rx_bit_i <= PAT[i % 32];
            @(posedge mclk_i);
        end
        rx_bit_valid_i <= 1'b0;
        repeat (hold + 1) @(posedge mclk_i);
        rx_active_i <= 1'b0;
        repeat (12) @(posedge mclk_i);
        for (int k = 0; k < 400 && link.crs_dv !== 1'b0; k++) @(posedge mclk_i);
        repeat (12) @(posedge mclk_i);
    endtask
    task automatic take;
        @(negedge mclk_i);
        for (int k = 0; k < 12 && tx_ready_o !== 1'b1; k++) @(negedge mclk_i);
        @(posedge mclk_i);
    endtask
    task automatic count_tog(output int nref, output int ncore);
        logic pr, pc;
        nref = 0;
        ncore = 0;
        @(negedge mclk_i);
        pr = link.ref_clk;
        pc = core_en_o;
        repeat (12) begin
            @(negedge mclk_i);
            if (link.ref_clk !== pr) nref++;
            if (core_en_o !== pc) ncore++;
            pr = link.ref_clk;
            pc = core_en_o;
        end
        @(posedge mclk_i);
    endtask
    task automatic complete_run;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        complete_run();
    end

    initial begin
        int nr, nc;
        logic [31:0] msk;
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(4'h0, 16'hFFFF, 16'h0011);
        wr(4'h5, 16'hFFFF);
        rd(4'h5, 16'hFFFF, 16'h0000);
        rd(4'h0, 16'hFFFF, 16'h0011);
        $display("test reset done");
        foreach (rows[r]) begin
            msk = (32'h1 << rows[r].nb) - 32'h1;
            set_cfg(rows[r].cfg);
            rx_pkt(rows[r].nb, 0);
            chk(ngot, rows[r].nb);
            chk(got & msk, PAT & msk);
            chk(err_seen, 0);
            chk(crs_o, 0);
            tx_q.delete();
            tx_c.delete();
            tx_valid_i <= 1'b1;
            tx_data_i <= 4'hE;
            take();
            tx_data_i <= 4'h7;
            take();
            tx_valid_i <= 1'b0;
            repeat (24) @(posedge mclk_i);
            chk(tx_q.size(), 2);
            chk(tx_en_o, 0);
            chk(tx_q[0], rows[r].cfg[4] ? 4'h2 : 4'hE);
            chk(tx_q[1], rows[r].cfg[4] ? 4'h3 : 4'h7);
            chk(tx_c[1] - tx_c[0], rows[r].gap);
            $display("row %0d done", r);
        end
        set_cfg(16'h0011);
        rx_pkt(2, 6);
        chk(err_seen, 1);
        rd(4'h0, 16'h0300, 16'h0100);
        wr(4'h0, 16'h0111);
        rd(4'h0, 16'h0300, 16'h0000);
        set_cfg(16'h0050);
        rx_pkt(40, 0);
        chk(err_seen, 1);
        chk(got === PAT, 0);
        rd(4'h0, 16'h0200, 16'h0200);
        wr(4'h0, 16'h0311);
        $display("test buffer faults done");
        set_cfg(16'h0010);
        fork
            rx_pkt(14, 0);
            begin
                wait (link.rx_dv === 1'b1);
                @(posedge mclk_i);
                rx_sym_err_i <= 1'b1;
                @(posedge mclk_i);
                rx_sym_err_i <= 1'b0;
            end
        join
        chk(err_seen, 1);
        chk(got[13:12], {30'h0, ~PAT[13:12]});
        err_seen = 1'b0;
        rx_false_carrier_i <= 1'b1;
        @(posedge mclk_i);
        rx_false_carrier_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        chk(err_seen, 1);
        $display("test receive errors done");
        count_tog(nr, nc);
        chk(nc, 12);
        set_cfg(16'h0031);
        count_tog(nr, nc);
        chk(nr, 12);
        chk(nc, 0);
        phy_reset_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        count_tog(nr, nc);
        chk(nr, 6);
        phy_reset_i <= 1'b0;
        $display("test clocks done");
        complete_run();
    end
endmodule
`default_nettype wire
